// ==== core/aoc_pkg.sv ====
package aoc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DW       = 11;
    localparam int PAIRS    = 6;
    localparam int AW       = 8;
    localparam int RW       = 32;
    localparam int ACC_W    = 41;
    localparam int PIN_W    = 5;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_DRIVE  = 8'h08;
    localparam logic [7:0] REG_EST_A  = 8'h0c;
    localparam logic [7:0] REG_EST_B  = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    localparam int CTRL_TWOS_BIT   = 0;
    localparam int CTRL_DDR_BIT    = 1;
    localparam int CTRL_LOWLAT_BIT = 2;
    localparam int CTRL_PDM_LSB    = 8;
    localparam int OFS_EN_BIT      = 0;
    localparam int OFS_FRZ_BIT     = 1;
    localparam int OFS_TC_LSB      = 4;
    localparam int DRV_CUR_LSB     = 0;
    localparam int DRV_DBL_BIT     = 2;
    localparam int DRV_TERM_LSB    = 4;
    localparam int DRV_DATA_BIT    = 8;
    localparam int DRV_CLK_BIT     = 9;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [31:0] DRIVE_RST  = 32'h0000_0000;

    // buffer current codes, 3.5 mA is the reset code
    localparam logic [1:0] CUR_3P5  = 2'h0;
    localparam logic [1:0] CUR_2P5  = 2'h1;
    localparam logic [1:0] CUR_4P5  = 2'h2;
    localparam logic [1:0] CUR_1P75 = 2'h3;

    // power-state field codes
    localparam logic [2:0] PDM_A_OFF  = 3'h1;
    localparam logic [2:0] PDM_B_OFF  = 3'h2;
    localparam logic [2:0] PDM_AB_OFF = 3'h3;
    localparam logic [2:0] PDM_GLOBAL = 3'h4;
    localparam logic [2:0] PDM_MUX    = 3'h7;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    localparam int LAT_DEFAULT = 14;
    localparam int LAT_LOW     = 10;
    localparam int DL_DEPTH    = 14;

    localparam logic [10:0] MSB_FLIP     = 11'h400;
    localparam logic [10:0] OVR_POS_BIN  = 11'h7ff;
    localparam logic [10:0] OVR_POS_TWOS = 11'h3ff;
    localparam logic [10:0] OVR_NEG_BIN  = 11'h000;
    localparam logic [10:0] OVR_NEG_TWOS = 11'h400;

    // four ref_clk cycles per sample: two high, two low on the forwarded clock
    typedef enum logic [1:0] {
        AOC_PH_HI0 = 2'b00,
        AOC_PH_HI1 = 2'b01,
        AOC_PH_LO0 = 2'b10,
        AOC_PH_LO1 = 2'b11
    } aoc_phase_t;

    // offset loop time constant as a power of two
    function automatic logic [4:0] tc_shift(input logic [2:0] code);
        case (code)
            3'h0:    tc_shift = 5'h1b;
            3'h1:    tc_shift = 5'h1a;
            3'h2:    tc_shift = 5'h19;
            3'h3:    tc_shift = 5'h18;
            3'h4:    tc_shift = 5'h1c;
            3'h5:    tc_shift = 5'h1d;
            default: tc_shift = 5'h1b;
        endcase
    endfunction

endpackage

// ==== core/aoc_offset_loop.sv ====
module aoc_offset_loop (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 sample_en,
    input  wire logic                 loop_en,
    input  wire logic                 freeze,
    input  wire logic [2:0]           tc_code,
    input  wire logic signed [10:0]   sample_in,
    output wire logic signed [10:0]   estimate
);
    localparam int DW = aoc_pkg::DW;
    localparam int AW = aoc_pkg::ACC_W;

    logic        [4:0]    shift;
    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] acc_d;
    logic signed [AW-1:0] leak;
    logic signed [AW-1:0] x_ext;

    assign shift = aoc_pkg::tc_shift(tc_code);                          // RULE19
    assign leak  = acc_q >>> shift;
    assign x_ext = {{(AW-DW){sample_in[DW-1]}}, sample_in};
    // leaky integrator: acc settles at mean * 2^shift
    // cleared while disabled so a re-enable starts from zero
    assign acc_d = !loop_en ? '0 :                                      // RULE21
                   (freeze || !sample_en) ? acc_q :                     // RULE20
                   acc_q + x_ext - leak;                                // RULE18
    assign estimate = leak[DW-1:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    freeze_hold_a: assert property (                                    // RULE20
        (loop_en && freeze && $past(loop_en) && $past(freeze) && $stable(tc_code))
        |-> $stable(estimate))
        else $error("offset estimate moved while frozen");

    off_zero_a: assert property (                                       // RULE21
        (!loop_en && $past(!loop_en)) |-> (estimate == '0))
        else $error("offset estimate nonzero while disabled");

endmodule // aoc_offset_loop

// ==== core/aoc_output_path.sv ====
// Operation
// [RULE1] ddr: eleven bits per channel, one shared clock
// [RULE2] each pair carries two bits per sample period
// [RULE3] odd bits at rising, even at falling edge
// [RULE4] receiver samples on both forwarded clock edges
// [RULE5] four buffer currents, 3.5 mA default
// [RULE6] current double doubles data and clock current
// [RULE7] three termination enables, eight combinations
// [RULE8] separate data and clock drive strength
// [RULE9] twos complement or binary, register or pin
// [RULE10] positive overdrive gives full-scale high code
// [RULE11] negative overdrive gives full-scale low code
// [RULE12] multiplexing only in parallel single-ended mode
// [RULE13] mux uses channel b bus, a tristated
// [RULE14] multiplexed mode only below 65 MSPS
// [RULE15] power-state 111 or all pins high: mux
// [RULE16] latency 14 samples, 10 in low latency
// [RULE17] low latency bypasses offset correction
// [RULE18] enabled loop estimates and subtracts offset
// [RULE19] time constant field maps to power of two
// [RULE20] freeze holds estimate, still applied
// [RULE21] offset correction off after reset
// [RULE22] mux: a word at rise, b at fall
module aoc_output_path (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [31:0]  reg_rdata,
    input  wire logic [10:0]  sample_a,
    input  wire logic [10:0]  sample_b,
    input  wire logic         ovr_pos_a,
    input  wire logic         ovr_neg_a,
    input  wire logic         ovr_pos_b,
    input  wire logic         ovr_neg_b,
    input  wire logic         parallel_config_mode,
    input  wire logic         serial_select_pin,
    input  wire logic [2:0]   parallel_control_pins,
    output logic              forwarded_clock,
    output logic      [10:0]  channel_a_bus,
    output logic              channel_a_oe_n,
    output logic      [10:0]  channel_b_bus,
    output logic              channel_b_oe_n,
    output logic      [5:0]   ddr_a,
    output logic      [5:0]   ddr_b,
    output logic              ddr_oe_n,
    output logic      [1:0]   lvds_current_sel,
    output logic              current_double,
    output logic      [2:0]   termination_sel,
    output logic              data_drive_level,
    output logic              clock_drive_level
);
    localparam int DW = aoc_pkg::DW;
    localparam int PW = aoc_pkg::PAIRS;
    localparam int RW = aoc_pkg::RW;
    localparam int ND = aoc_pkg::DL_DEPTH;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pair k carries bit 2k+1 then bit 2k; the top pair has no odd bit
    function automatic logic [5:0] odd_bits(input logic [10:0] w);
        logic [11:0] x;
        x = {1'b0, w};
        for (int k = 0; k < 6; k++) begin
            odd_bits[k] = x[2*k+1];
        end
    endfunction

    function automatic logic [5:0] even_bits(input logic [10:0] w);
        even_bits = '0;
        for (int k = 0; k < 6; k++) begin
            even_bits[k] = w[2*k];
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {parallel_config_mode, serial_select_pin, parallel_control_pins};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] ofs_q;
    logic [31:0] drv_q;
    logic [31:0] rdata_d;
    logic [31:0] status_w;
    logic        wr_ctrl;
    logic        wr_ofs;
    logic        wr_drv;

    assign wr_ctrl = reg_wr && (reg_addr == aoc_pkg::REG_CTRL);
    assign wr_ofs  = reg_wr && (reg_addr == aoc_pkg::REG_OFFSET);
    assign wr_drv  = reg_wr && (reg_addr == aoc_pkg::REG_DRIVE);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= aoc_pkg::CTRL_RST;
            ofs_q  <= aoc_pkg::OFFSET_RST;                             // RULE21
            drv_q  <= aoc_pkg::DRIVE_RST;                              // RULE5
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end
            if (wr_ofs) begin
                ofs_q <= reg_wdata;
            end
            if (wr_drv) begin
                drv_q <= reg_wdata;
            end
        end
    end

    // buffer controls leave the block straight from the drive register
    assign lvds_current_sel  = drv_q[aoc_pkg::DRV_CUR_LSB +: 2];      // RULE5
    assign current_double    = drv_q[aoc_pkg::DRV_DBL_BIT];           // RULE6
    assign termination_sel   = drv_q[aoc_pkg::DRV_TERM_LSB +: 3];     // RULE7
    assign data_drive_level  = drv_q[aoc_pkg::DRV_DATA_BIT];          // RULE8
    assign clock_drive_level = drv_q[aoc_pkg::DRV_CLK_BIT];           // RULE8

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic       par_mode;
    logic       eff_twos;
    logic [2:0] eff_pdm;
    logic       ddr_on;
    logic       mux_on;
    logic       low_lat;
    logic       corr_on;
    logic       a_off;
    logic       b_off;

    assign par_mode = pin_s2_q[4];
    assign eff_twos = par_mode ? pin_s2_q[3] : ctrl_q[aoc_pkg::CTRL_TWOS_BIT];      // RULE9
    assign eff_pdm  = par_mode ? pin_s2_q[2:0] : ctrl_q[aoc_pkg::CTRL_PDM_LSB +: 3];
    assign ddr_on   = ctrl_q[aoc_pkg::CTRL_DDR_BIT];
    assign mux_on   = (eff_pdm == aoc_pkg::PDM_MUX) && !ddr_on;        // RULE12 RULE15
    assign low_lat  = ctrl_q[aoc_pkg::CTRL_LOWLAT_BIT];
    assign corr_on  = ofs_q[aoc_pkg::OFS_EN_BIT] && !low_lat;          // RULE17
    assign a_off    = ddr_on || mux_on || (eff_pdm == aoc_pkg::PDM_A_OFF)
                      || (eff_pdm == aoc_pkg::PDM_AB_OFF) || (eff_pdm == aoc_pkg::PDM_GLOBAL);
    assign b_off    = ddr_on || (eff_pdm == aoc_pkg::PDM_B_OFF)
                      || (eff_pdm == aoc_pkg::PDM_AB_OFF) || (eff_pdm == aoc_pkg::PDM_GLOBAL);

    // ------------------------------------------------------------
    // sample phase divider
    // ------------------------------------------------------------
    aoc_pkg::aoc_phase_t phase_q;
    aoc_pkg::aoc_phase_t phase_d;
    logic                sample_en;
    logic                fall_en;

    always_comb begin
        case (phase_q)
            aoc_pkg::AOC_PH_HI0: phase_d = aoc_pkg::AOC_PH_HI1;
            aoc_pkg::AOC_PH_HI1: phase_d = aoc_pkg::AOC_PH_LO0;
            aoc_pkg::AOC_PH_LO0: phase_d = aoc_pkg::AOC_PH_LO1;
            default:             phase_d = aoc_pkg::AOC_PH_HI0;
        endcase
    end

    assign sample_en = (phase_q == aoc_pkg::AOC_PH_LO1);
    assign fall_en   = (phase_q == aoc_pkg::AOC_PH_HI1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= aoc_pkg::AOC_PH_HI0;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // per-channel correction, clamp and format
    // ------------------------------------------------------------
    logic [DW-1:0] raw_w  [0:1];
    logic          ovp_w  [0:1];
    logic          ovn_w  [0:1];
    logic [DW-1:0] proc_w [0:1];
    logic [DW-1:0] est_w  [0:1];

    assign raw_w[0] = sample_a;
    assign raw_w[1] = sample_b;
    assign ovp_w[0] = ovr_pos_a;
    assign ovp_w[1] = ovr_pos_b;
    assign ovn_w[0] = ovr_neg_a;
    assign ovn_w[1] = ovr_neg_b;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [DW-1:0] s_w;
        logic signed [DW-1:0] e_w;
        logic signed [DW:0]   diff_w;
        logic        [DW-1:0] sat_w;
        logic        [DW-1:0] cl_w;

        assign s_w = raw_w[ch] ^ aoc_pkg::MSB_FLIP;

        aoc_offset_loop u_loop (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .sample_en (sample_en),
            .loop_en   (corr_on),
            .freeze    (ofs_q[aoc_pkg::OFS_FRZ_BIT]),
            .tc_code   (ofs_q[aoc_pkg::OFS_TC_LSB +: 3]),
            .sample_in (s_w),
            .estimate  (e_w)
        );

        assign est_w[ch] = e_w;
        // estimate is zero while the loop is off, so the subtraction is a no-op
        assign diff_w = {s_w[DW-1], s_w} - {e_w[DW-1], e_w};          // RULE18
        assign sat_w  = (diff_w[DW] != diff_w[DW-1]) ?
                        (diff_w[DW] ? aoc_pkg::OVR_NEG_TWOS : aoc_pkg::OVR_POS_TWOS) :
                        diff_w[DW-1:0];
        // negative overdrive wins if the core flags both
        assign cl_w = ovn_w[ch] ? aoc_pkg::OVR_NEG_TWOS :             // RULE11
                      ovp_w[ch] ? aoc_pkg::OVR_POS_TWOS : sat_w;      // RULE10
        assign proc_w[ch] = eff_twos ? cl_w : (cl_w ^ aoc_pkg::MSB_FLIP);   // RULE9
    end

    // ------------------------------------------------------------
    // latency line
    // ------------------------------------------------------------
    logic [2*DW-1:0] dl_q [0:ND-1];
    logic [2*DW-1:0] tap_w;
    logic [2*DW-1:0] word_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dl_q[0] <= '0;
        end else if (sample_en) begin
            dl_q[0] <= {proc_w[1], proc_w[0]};
        end
    end

    for (genvar i = 1; i < ND; i++) begin : g_dl
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                dl_q[i] <= '0;
            end else if (sample_en) begin
                dl_q[i] <= dl_q[i-1];
            end
        end
    end

    // low latency taps earlier; the correction is already bypassed
    assign tap_w = low_lat ? dl_q[aoc_pkg::LAT_LOW-1] : dl_q[aoc_pkg::LAT_DEFAULT-1];   // RULE16

    // ------------------------------------------------------------
    // output launch
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q          <= '0;
            forwarded_clock <= 1'b0;
            ddr_a           <= '0;
            ddr_b           <= '0;
            channel_a_bus   <= '0;
            channel_b_bus   <= '0;
        end else if (sample_en) begin
            word_q          <= tap_w;
            forwarded_clock <= 1'b1;                                   // RULE1
            ddr_a           <= odd_bits(tap_w[DW-1:0]);                // RULE3
            ddr_b           <= odd_bits(tap_w[2*DW-1:DW]);             // RULE3
            channel_a_bus   <= tap_w[DW-1:0];
            // channel a word leads on the shared bus
            channel_b_bus   <= mux_on ? tap_w[DW-1:0] : tap_w[2*DW-1:DW];   // RULE13 RULE22
        end else if (fall_en) begin
            forwarded_clock <= 1'b0;
            ddr_a           <= even_bits(word_q[DW-1:0]);              // RULE2 RULE3
            ddr_b           <= even_bits(word_q[2*DW-1:DW]);           // RULE2 RULE3
            if (mux_on) begin
                channel_b_bus <= word_q[2*DW-1:DW];                    // RULE22
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ddr_oe_n       <= 1'b1;
            channel_a_oe_n <= 1'b1;
            channel_b_oe_n <= 1'b1;
        end else begin
            ddr_oe_n       <= !ddr_on;
            channel_a_oe_n <= a_off;                                   // RULE13
            channel_b_oe_n <= b_off;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    assign status_w = {24'h00_0000, ddr_on, mux_on, low_lat, corr_on, eff_twos, eff_pdm};

    always_comb begin
        case (reg_addr)
            aoc_pkg::REG_CTRL:   rdata_d = ctrl_q;
            aoc_pkg::REG_OFFSET: rdata_d = ofs_q;
            aoc_pkg::REG_DRIVE:  rdata_d = drv_q;
            aoc_pkg::REG_EST_A:  rdata_d = {{(RW-DW){est_w[0][DW-1]}}, est_w[0]};
            aoc_pkg::REG_EST_B:  rdata_d = {{(RW-DW){est_w[1][DW-1]}}, est_w[1]};
            aoc_pkg::REG_STATUS: rdata_d = status_w;
            default:             rdata_d = '0;
        endcase
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence clk_hi_lo_s;
        forwarded_clock [*2] ##1 !forwarded_clock [*2];
    endsequence

    fclk_shape_a: assert property (                                    // RULE2
        $rose(forwarded_clock) |-> clk_hi_lo_s)
        else $error("forwarded clock not two high two low");

    odd_launch_a: assert property (                                    // RULE3
        $rose(forwarded_clock) |-> (ddr_a == odd_bits(word_q[DW-1:0])))
        else $error("odd bits not on rising edge");

    even_launch_a: assert property (                                   // RULE3
        $fell(forwarded_clock) |-> (ddr_b == even_bits(word_q[2*DW-1:DW])))
        else $error("even bits not on falling edge");

    pos_clamp_a: assert property (                                     // RULE10
        (sample_en && ovr_pos_a && !ovr_neg_a) |=>
        (dl_q[0][DW-1:0] == ($past(eff_twos) ? aoc_pkg::OVR_POS_TWOS : aoc_pkg::OVR_POS_BIN)))
        else $error("positive overdrive code wrong");

    neg_clamp_a: assert property (                                     // RULE11
        (sample_en && ovr_neg_b) |=>
        (dl_q[0][2*DW-1:DW] == ($past(eff_twos) ? aoc_pkg::OVR_NEG_TWOS : aoc_pkg::OVR_NEG_BIN)))
        else $error("negative overdrive code wrong");

    ddr_no_mux_a: assert property (                                    // RULE12
        ddr_on |-> ##1 (!mux_on || !ddr_on) ##0 (ddr_oe_n == !$past(ddr_on)))
        else $error("mux active in ddr mode");

    a_tristate_a: assert property (                                    // RULE13
        (mux_on && $stable(mux_on)) |=> (channel_a_oe_n && !ddr_oe_n == 1'b0))
        else $error("channel a bus driven in mux mode");

    latency_a: assert property (                                       // RULE16
        (sample_en && !low_lat) |-> ##57 (low_lat || word_q[DW-1:0] == $past(proc_w[0], 57)))
        else $error("default latency not fourteen samples");

    low_latency_a: assert property (                                   // RULE16
        (sample_en && low_lat) |-> ##41 (!low_lat || word_q[DW-1:0] == $past(proc_w[0], 41)))
        else $error("low latency not ten samples");

endmodule // aoc_output_path

// ==== dv/aoc_rx_model.sv ====
module aoc_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        forwarded_clock,
    input  wire logic [5:0]  ddr_a,
    input  wire logic [5:0]  ddr_b,
    input  wire logic [10:0] channel_b_bus,
    output logic      [10:0] word_a,
    output logic      [10:0] word_b,
    output logic      [10:0] mux_a,
    output logic      [10:0] mux_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       fc_q;
    logic [5:0] odd_a, odd_b, even_a, even_b;
    // receiver sees the forwarded clock as a sampled level, edges found here
    always @(posedge ref_clk) begin
        fc_q <= forwarded_clock;
        if (forwarded_clock && !fc_q) begin
            odd_a <= ddr_a;
            odd_b <= ddr_b;
            mux_a <= channel_b_bus;
        end
        if (!forwarded_clock && fc_q) begin
            even_a <= ddr_a;
            even_b <= ddr_b;
            mux_b <= channel_b_bus;
        end
    end
    function automatic logic [10:0] join_bits(input logic [5:0] o, input logic [5:0] e);
        for (int k = 0; k < 6; k++) begin
            join_bits[2*k] = e[k];
            if (k < 5) join_bits[2*k+1] = o[k];
        end
    endfunction
    assign word_a = join_bits(odd_a, even_a);
    assign word_b = join_bits(odd_b, even_b);
endmodule // aoc_rx_model

// ==== dv/tb_adc_output_path_offset_corr.sv ====
module tb_adc_output_path_offset_corr;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [10:0] sa = 11'h123;
    logic [10:0] sb = 11'h456;
    logic        pos = 1'b0;
    logic        neg = 1'b0;
    logic        pcm = 1'b0;
    logic        ssel = 1'b0;
    logic [2:0]  pins = 3'h0;
    logic [31:0] v;
    wire logic [31:0] rdata;
    wire logic        fclk, oe_a_n, oe_b_n, ddr_oe_n, cdbl, dlev, clev;
    wire logic [10:0] bus_a, bus_b, wa, wb, ma, mb;
    wire logic [5:0]  da, db;
    wire logic [1:0]  cur;
    wire logic [2:0]  term;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    // 200 MHz; samples at a quarter of it stay below the mux rate limit
    always #2.5 ref_clk = ~ref_clk;

    aoc_output_path u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .sample_a(sa), .sample_b(sb), .ovr_pos_a(pos), .ovr_neg_a(neg),
        .ovr_pos_b(pos), .ovr_neg_b(neg), .parallel_config_mode(pcm),
        .serial_select_pin(ssel), .parallel_control_pins(pins),
        .forwarded_clock(fclk), .channel_a_bus(bus_a), .channel_a_oe_n(oe_a_n),
        .channel_b_bus(bus_b), .channel_b_oe_n(oe_b_n), .ddr_a(da), .ddr_b(db),
        .ddr_oe_n(ddr_oe_n), .lvds_current_sel(cur), .current_double(cdbl),
        .termination_sel(term), .data_drive_level(dlev), .clock_drive_level(clev));

    aoc_rx_model u_rx (.ref_clk(ref_clk), .forwarded_clock(fclk), .ddr_a(da),
        .ddr_b(db), .channel_b_bus(bus_b), .word_a(wa), .word_b(wb),
        .mux_a(ma), .mux_b(mb));

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input string what);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(what, e, rdata & m);
    endtask
    // covers pin sync plus the 14-sample pipe
    task automatic settle;
        repeat (100) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [10:0] exp11(input logic [10:0] s, input int f, input int o);
        if (o == 1) return f ? 11'h3ff : 11'h7ff;
        if (o == 2) return f ? 11'h400 : 11'h000;
        return f ? s ^ 11'h400 : s;
    endfunction

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk(aoc_pkg::REG_OFFSET, 32'h0, 32'hffffffff, "offset rst");
        rd_chk(aoc_pkg::REG_DRIVE, 32'h0, 32'hffffffff, "drive rst");
        rd_chk(8'h40, 32'h0, 32'hffffffff, "unmapped");
        for (int i = 0; i < 8; i++) begin
            v = {22'h0, i[1], i[0], 1'b0, i[2:0], 1'b0, i[2], i[1:0]};
            wr_reg(aoc_pkg::REG_DRIVE, v);
            @(posedge ref_clk);
            #1 chk("drive pins", {22'h0, v[9:8], v[6:4], v[2:0]},
                   {22'h0, clev, dlev, term, cdbl, cur});
            rd_chk(aoc_pkg::REG_DRIVE, v, 32'hffffffff, "drive rb");
        end
        for (int f = 0; f < 2; f++) begin
            for (int o = 0; o < 3; o++) begin
                @(posedge ref_clk);
                pos <= (o == 1);
                neg <= (o == 2);
                wr_reg(aoc_pkg::REG_CTRL, 32'(f));
                settle;
                chk("bus a", {21'h0, exp11(sa, f, o)}, {21'h0, bus_a});
                chk("bus b", {21'h0, exp11(sb, f, o)}, {21'h0, bus_b});
            end
        end
        @(posedge ref_clk);
        pos <= 1'b0;
        neg <= 1'b0;
        pcm <= 1'b1;
        ssel <= 1'b0;
        settle;
        chk("pin format", {21'h0, sa}, {21'h0, bus_a});
        @(posedge ref_clk);
        pins <= 3'h7;
        settle;
        chk("pin mux a oe", 32'h1, {31'h0, oe_a_n});
        @(posedge ref_clk);
        pcm <= 1'b0;
        ssel <= 1'b0;
        pins <= 3'h0;
        wr_reg(aoc_pkg::REG_CTRL, 32'h700);
        settle;
        chk("mux a word", {21'h0, sa}, {21'h0, ma});
        chk("mux b word", {21'h0, sb}, {21'h0, mb});
        chk("mux a oe", 32'h1, {31'h0, oe_a_n});
        chk("mux b oe", 32'h0, {31'h0, oe_b_n});
        // mux code left set: ddr must still win
        wr_reg(aoc_pkg::REG_CTRL, 32'h702);
        settle;
        chk("ddr a word", {21'h0, sa}, {21'h0, wa});
        chk("ddr b word", {21'h0, sb}, {21'h0, wb});
        chk("ddr oe", 32'h0, {31'h0, ddr_oe_n});
        rd_chk(aoc_pkg::REG_STATUS, 32'h80, 32'hc0, "ddr status");
        wr_reg(aoc_pkg::REG_CTRL, 32'h0);
        wr_reg(aoc_pkg::REG_OFFSET, 32'h61);
        rd_chk(aoc_pkg::REG_OFFSET, 32'h61, 32'hffffffff, "offset rb");
        rd_chk(aoc_pkg::REG_STATUS, 32'h10, 32'h10, "corr on");
        wr_reg(aoc_pkg::REG_OFFSET, 32'h63);
        rd_chk(aoc_pkg::REG_OFFSET, 32'h63, 32'hffffffff, "freeze rb");
        rd_chk(aoc_pkg::REG_EST_A, 32'hffffffff, 32'hffffffff, "est frozen");
        settle;
        chk("corr a", {21'h0, sa + 11'h1}, {21'h0, bus_a});
        wr_reg(aoc_pkg::REG_CTRL, 32'h4);
        rd_chk(aoc_pkg::REG_STATUS, 32'h20, 32'h30, "low lat");
        settle;
        chk("bypass a", {21'h0, sa}, {21'h0, bus_a});
        report_and_stop;
    end
endmodule // tb_adc_output_path_offset_corr
